// [rtl/ebac_cpu.sv]
// CPU end: runs storage write and read sequences on software command.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ebac_cpu
  import ebac_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_we,
  input  wire logic       i_re,
  output var  logic [7:0] o_rdata,
  ebac_if.cpu             bus
);

  ebac_state_t state_q;
  logic        is_write_q;
  logic [6:0]  addr_q;
  logic [7:0]  data_q;
  logic [7:0]  rbyte_q;
  logic        done_q;
  logic        gie_q;
  logic        pdn_q;
  logic        rie_q;
  logic [7:0]  rdata_q;
  logic [5:0]  io_addr_q;
  logic [7:0]  io_wdata_q;
  logic        io_we_q;
  logic        io_re_q;
  logic        go_wr;
  logic        go_rd;
  logic        idle;
  logic        gie_out_q;

  assign idle  = (state_q == EBAC_S_IDLE);
  assign go_wr = i_we && (i_addr == EBAC_H_CMD) && i_wdata[0] && idle;
  assign go_rd = i_we && (i_addr == EBAC_H_CMD) && i_wdata[1] && idle
                 && !i_wdata[0];

  // Command parameters and controls.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      addr_q <= 7'h00;
      data_q <= 8'h00;
      gie_q  <= 1'b0;
      pdn_q  <= 1'b0;
      rie_q  <= 1'b0;
    end else if (i_we) begin
      if (i_addr == EBAC_H_ADDR) begin
        addr_q <= i_wdata[6:0];
      end
      if (i_addr == EBAC_H_DATA) begin
        data_q <= i_wdata;
      end
      if (i_addr == EBAC_H_CTRL) begin
        gie_q <= i_wdata[0];
        pdn_q <= i_wdata[1];
        rie_q <= i_wdata[2];
      end
    end
  end

  // Sequencer; it issues nothing while the device stalls the CPU.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_q    <= EBAC_S_IDLE;
      is_write_q <= 1'b0;
      rbyte_q    <= 8'h00;
    end else if (!bus.cpu_stall) begin
      case (state_q)
        EBAC_S_IDLE: begin
          if (go_wr || go_rd) begin
            state_q    <= EBAC_S_POLL;
            is_write_q <= go_wr;
          end
        end
        EBAC_S_POLL:  state_q <= EBAC_S_CHECK;
        EBAC_S_CHECK: begin
          if (bus.io_rdata[EBAC_BIT_WSTROBE]) begin
            state_q <= EBAC_S_POLL;
          end else begin
            state_q <= EBAC_S_ADDR;
          end
        end
        EBAC_S_ADDR:
          state_q <= is_write_q ? EBAC_S_DATA : EBAC_S_RSTB;
        EBAC_S_DATA:  state_q <= EBAC_S_MWE;
        EBAC_S_MWE:   state_q <= EBAC_S_WSTB;
        EBAC_S_WSTB:  state_q <= EBAC_S_IDLE;
        EBAC_S_RSTB:  state_q <= EBAC_S_RREQ;
        // Waits out the stall that the read strobe brings.
        EBAC_S_RREQ: begin
          if (!io_we_q) begin
            state_q <= EBAC_S_RCAP;
          end
        end
        // Data stand in the cycle after the request has left the bus.
        EBAC_S_RCAP: begin
          if (!io_re_q) begin
            rbyte_q <= bus.io_rdata;
            state_q <= EBAC_S_IDLE;
          end
        end
        default:      state_q <= EBAC_S_IDLE;
      endcase
    end
  end

  // Bus strobes, registered; the strobe is sent one step ahead of need.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      io_addr_q  <= 6'h00;
      io_wdata_q <= 8'h00;
      io_we_q    <= 1'b0;
      io_re_q    <= 1'b0;
    end else begin
      io_we_q    <= 1'b0;
      io_re_q    <= 1'b0;
      io_wdata_q <= 8'h00;
      io_addr_q  <= 6'h00;
      if (!bus.cpu_stall) begin
        case (state_q)
          // The status read leaves with the step into the poll state, so
          // its answer stands when the check state samples it.
          EBAC_S_IDLE: begin
            if (go_wr || go_rd) begin
              io_re_q   <= 1'b1;
              io_addr_q <= EBAC_OFS_CONTROL;
            end
          end
          EBAC_S_CHECK: begin
            if (bus.io_rdata[EBAC_BIT_WSTROBE]) begin
              io_re_q   <= 1'b1;
              io_addr_q <= EBAC_OFS_CONTROL;
            end
          end
          EBAC_S_ADDR: begin
            io_we_q    <= 1'b1;
            io_addr_q  <= EBAC_OFS_ADDRESS;
            io_wdata_q <= {1'b0, addr_q};
          end
          EBAC_S_DATA: begin
            io_we_q    <= 1'b1;
            io_addr_q  <= EBAC_OFS_DATA;
            io_wdata_q <= data_q;
          end
          EBAC_S_MWE: begin
            io_we_q    <= 1'b1;
            io_addr_q  <= EBAC_OFS_CONTROL;
            io_wdata_q <= {4'h0, rie_q, 3'b100};
          end
          EBAC_S_WSTB: begin
            io_we_q    <= 1'b1;
            io_addr_q  <= EBAC_OFS_CONTROL;
            io_wdata_q <= {4'h0, rie_q, 3'b010};
          end
          EBAC_S_RSTB: begin
            io_we_q    <= 1'b1;
            io_addr_q  <= EBAC_OFS_CONTROL;
            io_wdata_q <= {4'h0, rie_q, 3'b001};
          end
          EBAC_S_RREQ: begin
            if (!io_we_q) begin
              io_re_q   <= 1'b1;
              io_addr_q <= EBAC_OFS_DATA;
            end
          end
          default: begin
            io_we_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Done flag: completion wins over a clear in the same cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
    end else if (!bus.cpu_stall && (state_q == EBAC_S_WSTB
                 || (state_q == EBAC_S_RCAP && !io_re_q))) begin
      done_q <= 1'b1;
    end else if (i_we && (i_addr == EBAC_H_STATUS) && i_wdata[1]) begin
      done_q <= 1'b0;
    end
  end

  // Interrupts are held off for the whole sequence so the arming window
  // cannot expire under an interrupt handler; the level drops in the
  // cycle after a command is taken, together with the first bus access.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      gie_out_q <= 1'b0;
    end else begin
      gie_out_q <= gie_q && idle && !go_wr && !go_rd;
    end
  end

  // Software register reads, data in the following cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_re) begin
      rdata_q <= 8'h00;
    end else begin
      case (i_addr)
        EBAC_H_ADDR:   rdata_q <= {1'b0, addr_q};
        EBAC_H_DATA:   rdata_q <= data_q;
        EBAC_H_STATUS: rdata_q <= {5'h00, bus.ready_irq, done_q, !idle};
        EBAC_H_CTRL:   rdata_q <= {5'h00, rie_q, pdn_q, gie_q};
        EBAC_H_RDATA:  rdata_q <= rbyte_q;
        default:       rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus.io_addr    = io_addr_q;
  assign bus.io_wdata   = io_wdata_q;
  assign bus.io_we      = io_we_q;
  assign bus.io_re      = io_re_q;
  assign bus.global_ie  = gie_out_q;
  assign bus.power_down = pdn_q;
  assign o_rdata        = rdata_q;

endmodule : ebac_cpu
`default_nettype wire

// [inc/ebac_pkg.sv]
// Shared constants for the storage byte access controller and its CPU end.
package ebac_pkg;

  // I/O space offsets of the storage registers.
  localparam logic [5:0] EBAC_OFS_CONTROL = 6'h1C;
  localparam logic [5:0] EBAC_OFS_DATA    = 6'h1D;
  localparam logic [5:0] EBAC_OFS_ADDRESS = 6'h1E;

  // Storage geometry.
  localparam int         EBAC_DEPTH       = 128;
  localparam int         EBAC_ADDR_W      = 7;
  localparam logic [6:0] EBAC_LAST_BYTE   = 7'h7F;

  // Control register fields and reset value.
  localparam int         EBAC_BIT_RSTROBE = 0;
  localparam int         EBAC_BIT_WSTROBE = 1;
  localparam int         EBAC_BIT_MWE     = 2;
  localparam int         EBAC_BIT_RIE     = 3;
  localparam logic [7:0] EBAC_CONTROL_RST = 8'h00;

  // Cycle counts on the system clock.
  localparam logic [2:0] EBAC_MWE_CYCLES   = 3'h4;
  localparam logic [2:0] EBAC_WSTALL_CYC   = 3'h2;
  localparam logic [2:0] EBAC_RSTALL_CYC   = 3'h4;

  // Programming interval, timed from the 1 MHz RC time base.
  localparam int         EBAC_SYS_CLK_HZ   = 125_000_000;
  localparam int         EBAC_RC_CLK_HZ    = 1_000_000;
  localparam int         EBAC_RC_DIV       = EBAC_SYS_CLK_HZ / EBAC_RC_CLK_HZ;
  localparam logic [6:0] EBAC_RC_DIV_LAST  = 7'(EBAC_RC_DIV - 1);
  localparam int         EBAC_PROG_RC_CYC  = 8448;
  localparam int         EBAC_PROG_W       = 14;

  // Offsets of the CPU end's own command registers.
  localparam logic [2:0] EBAC_H_CMD    = 3'h0;
  localparam logic [2:0] EBAC_H_ADDR   = 3'h1;
  localparam logic [2:0] EBAC_H_DATA   = 3'h2;
  localparam logic [2:0] EBAC_H_STATUS = 3'h3;
  localparam logic [2:0] EBAC_H_CTRL   = 3'h4;
  localparam logic [2:0] EBAC_H_RDATA  = 3'h5;

  // CPU end sequencer; Gray steps along the write and read paths, except the returns to idle.
  typedef enum logic [3:0] {
    EBAC_S_IDLE  = 4'h0,
    EBAC_S_POLL  = 4'h1,
    EBAC_S_CHECK = 4'h3,
    EBAC_S_ADDR  = 4'h2,
    EBAC_S_DATA  = 4'h6,
    EBAC_S_MWE   = 4'h7,
    EBAC_S_WSTB  = 4'h5,
    EBAC_S_RSTB  = 4'hA,
    EBAC_S_RREQ  = 4'hB,
    EBAC_S_RCAP  = 4'hF
  } ebac_state_t;

endpackage : ebac_pkg

// [inc/ebac_if.sv]
// Interface joining the CPU end to the storage byte access controller.
`timescale 1ns/1ps
`default_nettype none
interface ebac_if;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_we;
  logic       io_re;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  logic       ready_irq;
  logic       global_ie;
  logic       power_down;

  modport dev (
    input  io_addr,
    input  io_wdata,
    input  io_we,
    input  io_re,
    output io_rdata,
    output cpu_stall,
    output ready_irq,
    input  global_ie,
    input  power_down
  );

  modport cpu (
    output io_addr,
    output io_wdata,
    output io_we,
    output io_re,
    input  io_rdata,
    input  cpu_stall,
    input  ready_irq,
    output global_ie,
    output power_down
  );
endinterface : ebac_if
`default_nettype wire

// [rtl/ebac_dev.sv]
// Storage byte access controller: registers, byte store and write timer.
//
// Contract
// - 128 bytes, linear addresses 0 to 127.
// - Address bits 6..0 used; bit 7 reads zero.
// - Software loads address before any access.
// - Control bits 7..4 read zero; reset zero.
// - Level interrupt while enabled and strobe zero.
// - Master write enable self-clears after four cycles.
// - Write strobe starts only with master enable.
// - Software arms, then strobes within four cycles.
// - Strobe clears after 8448 RC cycles.
// - Interval timed from the 1 MHz base.
// - Write strobe stalls the CPU two cycles.
// - Read strobe fetches byte, clears, stalls four.
// - Read completes within the strobing instruction.
// - Ongoing write survives a reset.
// - Address or data write aborts ongoing write.
// - Software checks strobe zero before reading.
// - Software keeps interrupts off during writes.
// - Write completes in power-down; oscillator stays.
`timescale 1ns/1ps
`default_nettype none
module ebac_dev
  import ebac_pkg::*;
#(
  parameter int P_PROG_RC_CYC = EBAC_PROG_RC_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_por_b,
  output var  logic o_osc_keep,
  ebac_if.dev       bus
);

  logic [7:0]             mem_q [EBAC_DEPTH];
  logic [EBAC_ADDR_W-1:0] addr_q;
  logic [7:0]             data_q;
  logic                   rie_q;
  logic                   mwe_q;
  logic [2:0]             mwe_cnt_q;
  logic                   busy_q;
  logic [6:0]             rc_div_q;
  logic [EBAC_PROG_W-1:0] prog_cnt_q;
  logic [2:0]             stall_cnt_q;
  logic                   stall_q;
  logic                   irq_q;
  logic [7:0]             rdata_q;
  logic                   osc_keep_q;

  logic wr_ctl;
  logic wr_addr;
  logic wr_data;
  logic start_wr;
  logic start_rd;
  logic rc_tick;
  logic prog_done;
  logic abort_wr;

  assign wr_ctl   = bus.io_we && (bus.io_addr == EBAC_OFS_CONTROL);
  assign wr_addr  = bus.io_we && (bus.io_addr == EBAC_OFS_ADDRESS);
  assign wr_data  = bus.io_we && (bus.io_addr == EBAC_OFS_DATA);
  // A strobe needs the enable as it stood before this write.
  assign start_wr = wr_ctl && bus.io_wdata[EBAC_BIT_WSTROBE]
                    && mwe_q && !busy_q;
  // A read during programming would see a half-written cell, so it is
  // refused; software is expected to have polled the strobe first.
  assign start_rd = wr_ctl && bus.io_wdata[EBAC_BIT_RSTROBE]
                    && !busy_q && !start_wr;
  assign abort_wr = busy_q && (wr_addr || wr_data);
  assign rc_tick  = (rc_div_q == EBAC_RC_DIV_LAST);
  assign prog_done = busy_q && rc_tick && (prog_cnt_q == '0);

  // Address register; bit 7 is not stored and no reset applies.
  always_ff @(posedge i_clk_sys) begin
    if (wr_addr) begin
      addr_q <= bus.io_wdata[EBAC_ADDR_W-1:0];
    end
  end

  // Data register: loaded by software or by a read fetch.
  always_ff @(posedge i_clk_sys) begin
    if (wr_data) begin
      data_q <= bus.io_wdata;
    end else if (start_rd) begin
      data_q <= mem_q[addr_q];
    end
  end

  // Byte store; an aborted write leaves the cell as it was.
  always_ff @(posedge i_clk_sys) begin
    if (prog_done && !abort_wr) begin
      mem_q[addr_q] <= data_q;
    end
  end

  // Ready interrupt enable.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_por_b) begin
      rie_q <= 1'b0;
    end else if (wr_ctl) begin
      rie_q <= bus.io_wdata[EBAC_BIT_RIE];
    end
  end

  // Master write enable with its four-cycle lifetime.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_por_b) begin
      mwe_q     <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (wr_ctl && bus.io_wdata[EBAC_BIT_MWE]) begin
      mwe_q     <= 1'b1;
      mwe_cnt_q <= EBAC_MWE_CYCLES - 3'h1;
    end else if (mwe_q) begin
      if (mwe_cnt_q == 3'h0) begin
        mwe_q <= 1'b0;
      end else begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
    end
  end

  // Programming engine. Power-on clears it at any time, a plain reset only when idle; a plain reset during a
  // write lets the write run out, as the cell would otherwise be left
  // half programmed.
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_b || (!i_rst_b && !busy_q)) begin
      busy_q     <= 1'b0;
      prog_cnt_q <= '0;
    end else if (start_wr) begin
      busy_q     <= 1'b1;
      prog_cnt_q <= EBAC_PROG_W'(P_PROG_RC_CYC - 1);
    end else if (abort_wr || prog_done) begin
      busy_q     <= 1'b0;
    end else if (busy_q && rc_tick) begin
      prog_cnt_q <= prog_cnt_q - EBAC_PROG_W'(1);
    end
  end

  // 1 MHz time base from the system clock, restarted by each write strobe.
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_b || start_wr || rc_tick) begin
      rc_div_q <= 7'h00;
    end else begin
      rc_div_q <= rc_div_q + 7'h01;
    end
  end

  // CPU stall after a write or read strobe.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_por_b) begin
      stall_q     <= 1'b0;
      stall_cnt_q <= 3'h0;
    end else if (start_wr) begin
      stall_q     <= 1'b1;
      stall_cnt_q <= EBAC_WSTALL_CYC - 3'h1;
    end else if (start_rd) begin
      stall_q     <= 1'b1;
      stall_cnt_q <= EBAC_RSTALL_CYC - 3'h1;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end else begin
      stall_q     <= 1'b0;
    end
  end

  // Ready interrupt, a level for as long as no write runs.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_por_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= bus.global_ie && rie_q && !(busy_q && !prog_done);
    end
  end

  // Once power-down catches a write, the oscillator is held on until
  // power-down is left; the full low-power state is not reached.
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_b) begin
      osc_keep_q <= 1'b0;
    end else if (!bus.power_down) begin
      osc_keep_q <= 1'b0;
    end else if (busy_q) begin
      osc_keep_q <= 1'b1;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_por_b) begin
      rdata_q <= 8'h00;
    end else if (!bus.io_re) begin
      rdata_q <= 8'h00;
    end else begin
      case (bus.io_addr)
        EBAC_OFS_CONTROL: rdata_q <= {4'h0, rie_q, mwe_q,
                                      busy_q, 1'b0};
        EBAC_OFS_DATA:    rdata_q <= data_q;
        EBAC_OFS_ADDRESS: rdata_q <= {1'b0, addr_q};
        default:          rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus.io_rdata  = rdata_q;
  assign bus.cpu_stall = stall_q;
  assign bus.ready_irq = irq_q;
  assign o_osc_keep    = osc_keep_q;

endmodule : ebac_dev
`default_nettype wire

// [dv/ebac_checker.sv]
// Concurrent checks on the bus between the CPU end and the controller.
`timescale 1ns/1ps
`default_nettype none
module ebac_checker
  import ebac_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq,
  input wire logic       global_ie,
  input wire logic       power_down
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  logic [2:0] arm_q;
  logic       ctl_we;
  logic       ctl_re;
  logic       wstb_ok;

  assign ctl_we  = io_we && io_addr == EBAC_OFS_CONTROL;
  assign ctl_re  = io_re && io_addr == EBAC_OFS_CONTROL;
  assign wstb_ok = ctl_we && io_wdata[1] && arm_q != 3'h0;

  // Shadow of the arming window, so an accepted strobe can be told apart.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) arm_q <= 3'h0;
    else if (ctl_we && io_wdata[2]) arm_q <= 3'h4;
    else if (arm_q != 3'h0) arm_q <= arm_q - 3'h1;
  end

  write_stall_a: assert property (
    wstb_ok |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall length wrong");
  read_stall_a: assert property (
    ctl_we && io_wdata[0] |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  stall_quiet_a: assert property (
    cpu_stall |-> !io_we && !io_re)
    else $error("request issued during stall");
  rdata_idle_a: assert property (
    !$past(io_re) |-> io_rdata == 8'h00)
    else $error("read data outside its cycle");
  ctl_zero_a: assert property (
    $past(ctl_re) |-> io_rdata[7:4] == 4'h0 && !io_rdata[0])
    else $error("control reserved bits not zero");
  addr_msb_a: assert property (
    $past(io_re && io_addr == EBAC_OFS_ADDRESS) |-> !io_rdata[7])
    else $error("address bit 7 not zero");
  irq_gie_a: assert property (
    !global_ie |=> !ready_irq)
    else $error("interrupt without global enable");
  irq_busy_a: assert property (
    wstb_ok |-> ##2 !ready_irq [*4])
    else $error("interrupt while programming");
  arm_strobe_a: assert property (
    ctl_we && io_wdata[2] |-> ##[1:4] wstb_ok)
    else $error("strobe not within arming window");

  cover property (wstb_ok);
  cover property (ctl_we && io_wdata[0]);
  cover property (ready_irq);
  cover property (power_down && !ready_irq);
endmodule : ebac_checker
`default_nettype wire

// [dv/ebac_tb_top.sv]
// Self-checking bench: CPU end and controller joined back to back.
`timescale 1ns/1ps
`default_nettype none
module ebac_tb_top
  import ebac_pkg::*;
;
  // A short interval keeps the run small; expectations scale with it.
  localparam int P_RC = 4;
  localparam int BUSY = P_RC * EBAC_RC_DIV;

  logic       clk   = 1'b0;
  logic       rst_b = 1'b0;
  logic       por_b = 1'b0;
  logic [2:0] addr  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       we    = 1'b0;
  logic       re    = 1'b0;
  logic [7:0] rdata;
  logic       osc;
  int         mismatches = 0;
  int         check_count = 0;
  int         cycles = 0;

  ebac_if bus_if ();
  ebac_dev #(.P_PROG_RC_CYC(P_RC)) i_ebac_dev (.i_clk_sys(clk),
    .i_rst_b(rst_b), .i_por_b(por_b), .o_osc_keep(osc), .bus(bus_if.dev));
  ebac_cpu i_ebac_cpu (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
    .bus(bus_if.cpu));
  ebac_checker i_ebac_checker (.i_clk_sys(clk), .i_rst_b(rst_b),
    .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata),
    .io_we(bus_if.io_we), .io_re(bus_if.io_re),
    .io_rdata(bus_if.io_rdata), .cpu_stall(bus_if.cpu_stall),
    .ready_irq(bus_if.ready_irq), .global_ie(bus_if.global_ie),
    .power_down(bus_if.power_down));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_done();
    logic [7:0] s = 8'h00;
    for (int n = 0; n < 1500 && s[1] !== 1'b1; n++) rd(EBAC_H_STATUS, s);
    check(s & 8'h02, 8'h02);
    wr(EBAC_H_STATUS, 8'h02);
  endtask : wait_done

  task automatic start(input logic [7:0] a, input logic [7:0] d);
    wr(EBAC_H_ADDR, a);
    wr(EBAC_H_DATA, d);
    wr(EBAC_H_CMD, 8'h01);
  endtask : start

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    wr(EBAC_H_ADDR, a);
    wr(EBAC_H_CMD, 8'h02);
    wait_done();
    rd(EBAC_H_RDATA, d);
  endtask : get

  task automatic t_reset();
    tick();
    check({5'h00, bus_if.ready_irq, bus_if.cpu_stall, osc}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_store();
    logic [7:0] d;
    start(8'hFF, 8'hA5);
    wait_done();
    start(8'h00, 8'h3C);
    wait_done();
    get(8'h7F, d);
    check(d, 8'hA5);
    get(8'h80, d);
    check(d, 8'h3C);
    $display("test store done");
  endtask : t_store

  task automatic t_irq();
    logic [7:0] d;
    int         n = 0;
    wr(EBAC_H_CTRL, 8'h05);
    // The enable reaches the controller with the next sequence's
    // control write, so a read carries it across.
    get(8'h7F, d);
    check(d, 8'hA5);
    repeat (2) tick();
    check({7'h00, bus_if.ready_irq}, 8'h01);
    start(8'h10, 8'h5A);
    while (bus_if.ready_irq !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    n = 0;
    while (bus_if.ready_irq !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    check(8'(n >= BUSY && n <= BUSY + 40), 8'h01);
    wait_done();
    wr(EBAC_H_CTRL, 8'h04);
    repeat (3) tick();
    check({7'h00, bus_if.ready_irq}, 8'h00);
    get(8'h10, d);
    check(d, 8'h5A);
    $display("test irq done");
  endtask : t_irq

  task automatic t_mid_reset();
    logic [7:0] d;
    start(8'h20, 8'hC3);
    repeat (60) tick();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    get(8'h20, d);
    check(d, 8'hC3);
    $display("test mid reset done");
  endtask : t_mid_reset

  task automatic t_sleep();
    logic [7:0] d;
    start(8'h30, 8'h96);
    repeat (20) tick();
    wr(EBAC_H_CTRL, 8'h02);
    repeat (BUSY + 20) tick();
    check({7'h00, osc}, 8'h01);
    wr(EBAC_H_CTRL, 8'h00);
    repeat (3) tick();
    check({7'h00, osc}, 8'h00);
    wr(EBAC_H_STATUS, 8'h02);
    get(8'h30, d);
    check(d, 8'h96);
    $display("test sleep done");
  endtask : t_sleep

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    t_reset();
    t_store();
    t_irq();
    t_mid_reset();
    t_sleep();
    finish_test();
  end
endmodule : ebac_tb_top
`default_nettype wire
